// [afe_pkg.sv]
package afe_pkg;

   // register byte offsets
   localparam logic [7:0] MUX_CFG_OFS = 8'h00;
   localparam logic [7:0] TEMP_CTRL_OFS = 8'h04;
   localparam logic [7:0] TEMP_STAT_OFS = 8'h08;
   localparam logic [7:0] WAKE_CTRL_OFS = 8'h0C;
   localparam logic [7:0] PB_CTRL_OFS = 8'h10;
   localparam logic [7:0] EVT_STAT_OFS = 8'h14;
   localparam logic [7:0] AIO_CFG_OFS = 8'h18;

   // monitor mux channels
   localparam int MUX_CHANNELS = 21;
   localparam int MUX_SEL_W = 5;
   localparam logic [4:0] CH_AIO_BUF = 5'h06;
   localparam logic [4:0] CH_DIE_TEMP = 5'h0E;

   // field positions
   localparam int MUX_SRC_BIT = 8;
   localparam int TEMP_IE_BIT = 0;
   localparam int ST_W1_BIT = 0;
   localparam int ST_W2_BIT = 1;
   localparam int ST_FAULT_BIT = 2;
   localparam int WK_CHG_EN_BIT = 0;
   localparam int WK_PD_EN_BIT = 1;
   localparam int WK_LOAD_EN_BIT = 2;
   localparam int WK_HIB_BIT = 3;
   localparam int WK_THR_LSB = 4;
   localparam int PB_EN_BIT = 0;
   localparam int PB_POL_BIT = 1;
   localparam int PB_WAKE_BIT = 2;
   localparam int PB_IRQ_BIT = 3;
   localparam int PB_RST_BIT = 4;
   localparam int PB_PASS_BIT = 5;
   localparam int PB_UART_BIT = 6;
   localparam int PB_DG_LSB = 8;
   localparam int EV_CHG_BIT = 0;
   localparam int EV_LOAD_BIT = 1;
   localparam int EV_SHORT_BIT = 2;
   localparam int EV_PB_BIT = 3;
   localparam int EV_RX_BIT = 4;
   localparam int EV_LEVEL_BIT = 8;
   localparam int AIO_OUT_BIT = 0;
   localparam int AIO_SEL_LSB = 1;

   // reset values
   localparam logic [31:0] ZERO_RST = 32'h0000_0000;

   // temperature thresholds in degrees C
   localparam int WARN1_C = 120;
   localparam int WARN2_C = 140;
   localparam int FAULT_C = 155;
   localparam int HYST_C = 10;
   localparam int TEMP_W = 9;

   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int LONG_HOLD_S = 8;
   localparam int LONG_HOLD_CYC = LONG_HOLD_S * CLK_HZ;
   localparam int DG1_MS = 1;
   localparam int DG4_MS = 4;
   localparam int DG8_MS = 8;
   localparam int DG32_MS = 32;
   localparam int DG1_CYC = DG1_MS * (CLK_HZ / 1000);
   localparam int DG4_CYC = DG4_MS * (CLK_HZ / 1000);
   localparam int DG8_CYC = DG8_MS * (CLK_HZ / 1000);
   localparam int DG32_CYC = DG32_MS * (CLK_HZ / 1000);

   // aio output selections
   typedef enum logic [1:0] {
      AIO_REF, AIO_MONITOR, AIO_CURRENT, AIO_CELL
   } aio_sel_t;

   // power enables driven to the analog side
   typedef struct packed {
      logic charge_pump_en;
      logic dcdc_en;
      logic gate_drv_en;
   } power_en_t;

   // analog routing controls
   typedef struct packed {
      logic [4:0] monitor_sel;
      logic aio_out_mode;
      aio_sel_t aio_out_sel;
      logic aio_to_monitor;
   } route_t;

   // push-button pin controls
   typedef struct packed {
      logic pull_up_en;
      logic pull_down_en;
   } pb_bias_t;

endpackage

// [afe_monitor_wake_protect.sv]
// Operation
// RULE1: mux select from bus or sequencer
// RULE2: mux output routed to 12-bit converter
// RULE3: monitor mux offers twenty-one sources
// RULE4: warn1 latches flag, maskable interrupt
// RULE5: warn2 own flag, same interrupt
// RULE6: fault disables power, flag, no interrupt
// RULE7: ten degree hysteresis, dcdc re-enable
// RULE8: charger detect wakes from hibernate
// RULE9: software pack pull-down enable
// RULE10: load or short detect, off in hibernate
// RULE11: push-button level passed to gpio
// RULE12: serial receive activity wakes device
// RULE13: button wake, interrupt, reset, polarity
// RULE14: eight second hold issues reset; the code keeps the hold timer clear in hibernate, so no reset there
// RULE15: polarity selects pull-up or pull-down
// RULE16: deglitch 1, 4, 8 or 32 ms
// RULE17: aio input buffer feeds monitor mux
// RULE18: aio output drives one selected signal
// RULE19: temperature flags stay until cleared
// RULE20: filter first, hold timer after it
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
module afe_monitor_wake_protect #(
   parameter int LONG_HOLD = afe_pkg::LONG_HOLD_CYC,
   parameter int DG1 = afe_pkg::DG1_CYC,
   parameter int DG4 = afe_pkg::DG4_CYC,
   parameter int DG8 = afe_pkg::DG8_CYC,
   parameter int DG32 = afe_pkg::DG32_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // sequencer select path
   input wire logic [4:0] sequencer_channel_select,
   // analog comparators and detectors (asynchronous)
   input wire logic [8:0] die_temp_channel,
   input wire logic pack_above_thr,
   input wire logic load_detect_signal,
   input wire logic short_detect,
   input wire logic push_button_input,
   input wire logic uart_rx_pin,
   // analog controls
   output afe_pkg::route_t route,
   output afe_pkg::power_en_t power_en,
   output afe_pkg::pb_bias_t pb_bias,
   output logic [1:0] charge_thr_sel,
   output logic pack_pull_down_en,
   output logic load_detect_en,
   // processor side
   output logic temp_irq,
   output logic pb_irq,
   output logic shared_gpio_pin,
   output logic wake_event,
   output logic hw_reset
);

   // refuse timings the counters cannot hold
   if (LONG_HOLD < 1 || DG1 < 1 || DG4 < DG1 || DG8 < DG4 ||
       DG32 < DG8) begin
      $error("afe_monitor_wake_protect: bad timing parameters");
   end
   if (LONG_HOLD >= 2**29 || DG32 >= 2**29) begin
      $error("afe_monitor_wake_protect: count too wide");
   end

   localparam int CW = 29;

   //////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [13:0] sync1_q, sync2_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 14'h2000; // serial line idles high
         sync2_q <= 14'h2000;
      end else begin
         sync1_q <= {uart_rx_pin, push_button_input, short_detect,
                     load_detect_signal, pack_above_thr, die_temp_channel};
         sync2_q <= sync1_q;
      end
   end
   logic [8:0] temp_c;
   logic pack_s, load_s, short_s, pb_s, rx_s;
   assign temp_c = sync2_q[8:0];
   assign pack_s = sync2_q[9];
   assign load_s = sync2_q[10];
   assign short_s = sync2_q[11];
   assign pb_s = sync2_q[12];
   assign rx_s = sync2_q[13];

   //////////////////////////////////////////////////////////////////////
   // control registers
   logic [8:0] mux_cfg_q;
   logic temp_ie_q;
   logic [5:0] wake_ctrl_q;
   logic [9:0] pb_ctrl_q;
   logic [2:0] aio_cfg_q;
   logic [2:0] temp_stat_q;
   logic [4:0] evt_stat_q;
   logic pb_act_q;

   logic wr, rd_cycle;
   assign rd_cycle = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = rd_cycle && wb_we_i;

   // bus acknowledges one cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= rd_cycle;
   end

   // software control fields
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mux_cfg_q <= 9'h000;
         temp_ie_q <= 1'b0;
         wake_ctrl_q <= 6'h00;
         pb_ctrl_q <= 10'h000;
         aio_cfg_q <= 3'h0;
      end else if (wr && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            afe_pkg::MUX_CFG_OFS: mux_cfg_q[7:0] <= wb_dat_i[7:0];
            afe_pkg::TEMP_CTRL_OFS: temp_ie_q <= wb_dat_i[0];
            afe_pkg::WAKE_CTRL_OFS: wake_ctrl_q <= wb_dat_i[5:0];
            afe_pkg::PB_CTRL_OFS: pb_ctrl_q[7:0] <= wb_dat_i[7:0];
            afe_pkg::AIO_CFG_OFS: aio_cfg_q <= wb_dat_i[2:0];
            default: ;
         endcase
      end else if (wr && wb_sel_i[1]) begin
         unique case (wb_adr_i)
            afe_pkg::MUX_CFG_OFS: mux_cfg_q[8] <= wb_dat_i[8];
            afe_pkg::PB_CTRL_OFS: pb_ctrl_q[9:8] <= wb_dat_i[9:8];
            default: ;
         endcase
      end
   end

   // read data mux, unmapped reads as zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         wb_dat_o <= afe_pkg::ZERO_RST;
      else if (rd_cycle && !wb_we_i) begin
         unique case (wb_adr_i)
            afe_pkg::MUX_CFG_OFS: wb_dat_o <= {23'h0, mux_cfg_q};
            afe_pkg::TEMP_CTRL_OFS: wb_dat_o <= {31'h0, temp_ie_q};
            afe_pkg::TEMP_STAT_OFS: wb_dat_o <= {20'h0, temp_c,
                                                 temp_stat_q[2:0]};
            afe_pkg::WAKE_CTRL_OFS: wb_dat_o <= {26'h0, wake_ctrl_q};
            afe_pkg::PB_CTRL_OFS: wb_dat_o <= {22'h0, pb_ctrl_q};
            afe_pkg::EVT_STAT_OFS: wb_dat_o <= {23'h0, pb_act_q, 3'h0,
                                                evt_stat_q};
            afe_pkg::AIO_CFG_OFS: wb_dat_o <= {29'h0, aio_cfg_q};
            default: wb_dat_o <= afe_pkg::ZERO_RST;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // analog routing
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         route <= '0;
      else begin
         route.monitor_sel <= mux_cfg_q[afe_pkg::MUX_SRC_BIT] ?
            sequencer_channel_select : mux_cfg_q[4:0]; // see RULE1 RULE2
         route.aio_out_mode <= aio_cfg_q[afe_pkg::AIO_OUT_BIT];
         route.aio_out_sel <= afe_pkg::aio_sel_t'(aio_cfg_q[2:1]); // see RULE18
         route.aio_to_monitor <= !aio_cfg_q[afe_pkg::AIO_OUT_BIT]; // see RULE17
      end
   end
   // bus channel codes at or above the count hold load detection off (RULE3 sources)
   logic sel_bad;
   assign sel_bad = (mux_cfg_q[4:0] >= 5'(afe_pkg::MUX_CHANNELS)); // see RULE3

   //////////////////////////////////////////////////////////////////////
   // temperature comparators with hysteresis
   logic w1_q, w2_q, flt_q;
   function automatic logic hyst(input logic cur, input logic [8:0] t,
                                 input int thr);
      if (cur)
         return t > 9'(thr - afe_pkg::HYST_C);
      else
         return t > 9'(thr);
   endfunction
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         w1_q <= 1'b0;
         w2_q <= 1'b0;
         flt_q <= 1'b0;
      end else begin
         w1_q <= hyst(w1_q, temp_c, afe_pkg::WARN1_C); // see RULE7
         w2_q <= hyst(w2_q, temp_c, afe_pkg::WARN2_C); // see RULE7
         flt_q <= hyst(flt_q, temp_c, afe_pkg::FAULT_C); // see RULE7
      end
   end

   // latched flags, set wins over write-one-to-clear
   logic clr_temp, clr_evt;
   assign clr_temp = wr && wb_sel_i[0] && wb_adr_i == afe_pkg::TEMP_STAT_OFS;
   assign clr_evt = wr && wb_sel_i[0] && wb_adr_i == afe_pkg::EVT_STAT_OFS;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         temp_stat_q <= 3'h0;
      else
         temp_stat_q <= (temp_stat_q & ~({3{clr_temp}} & wb_dat_i[2:0]))
                        | {flt_q, w2_q, w1_q}; // see RULE4 RULE5 RULE6 RULE19
   end

   // shared interrupt for both warnings, never for fault
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         temp_irq <= 1'b0;
      else
         temp_irq <= temp_ie_q && (temp_stat_q[afe_pkg::ST_W1_BIT] ||
                     temp_stat_q[afe_pkg::ST_W2_BIT]); // see RULE4 RULE5 RULE6
   end

   // power shutdown during fault, restored at or below fault minus hysteresis
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         power_en <= '0;
      else begin
         power_en.charge_pump_en <= !flt_q; // see RULE6
         power_en.dcdc_en <= !flt_q; // see RULE7
         power_en.gate_drv_en <= !flt_q; // see RULE6
      end
   end

   //////////////////////////////////////////////////////////////////////
   // push-button deglitch and long hold
   logic pb_lvl, pb_act_d;
   logic [CW-1:0] dg_cnt_q, hold_cnt_q, dg_len;
   assign pb_lvl = pb_ctrl_q[afe_pkg::PB_EN_BIT] &&
                   (pb_s == pb_ctrl_q[afe_pkg::PB_POL_BIT]); // see RULE13
   always_comb begin
      unique case (pb_ctrl_q[9:8])
         2'h0: dg_len = CW'(DG1); // see RULE16
         2'h1: dg_len = CW'(DG4);
         2'h2: dg_len = CW'(DG8);
         2'h3: dg_len = CW'(DG32);
      endcase
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dg_cnt_q <= '0;
         pb_act_q <= 1'b0;
      end else if (pb_lvl == pb_act_q) begin
         dg_cnt_q <= '0;
      end else if (dg_cnt_q >= dg_len - 1'b1) begin
         dg_cnt_q <= '0;
         pb_act_q <= pb_lvl; // see RULE20
      end else begin
         dg_cnt_q <= dg_cnt_q + 1'b1;
      end
   end
   assign pb_act_d = pb_lvl && !pb_act_q && dg_cnt_q >= dg_len - 1'b1;

   // hold timer runs from the filtered level only
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         hold_cnt_q <= '0;
         hw_reset <= 1'b0;
      end else begin
         hw_reset <= 1'b0;
         if (!pb_act_q || !pb_ctrl_q[afe_pkg::PB_RST_BIT] ||
             wake_ctrl_q[afe_pkg::WK_HIB_BIT])
            hold_cnt_q <= '0; // see RULE20
         else if (hold_cnt_q == CW'(LONG_HOLD)) begin
            hw_reset <= 1'b1; // see RULE14
            hold_cnt_q <= '0;
         end else
            hold_cnt_q <= hold_cnt_q + 1'b1;
      end
   end

   // bias, pass-through and button interrupt
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pb_bias <= '0;
         shared_gpio_pin <= 1'b0;
         pb_irq <= 1'b0;
      end else begin
         pb_bias.pull_up_en <= pb_ctrl_q[afe_pkg::PB_EN_BIT] &&
                               !pb_ctrl_q[afe_pkg::PB_POL_BIT]; // see RULE15
         pb_bias.pull_down_en <= pb_ctrl_q[afe_pkg::PB_EN_BIT] &&
                                 pb_ctrl_q[afe_pkg::PB_POL_BIT]; // see RULE15
         shared_gpio_pin <= pb_ctrl_q[afe_pkg::PB_UART_BIT] ? rx_s :
            (pb_ctrl_q[afe_pkg::PB_PASS_BIT] && pb_s); // see RULE11
         pb_irq <= pb_ctrl_q[afe_pkg::PB_IRQ_BIT] &&
                   evt_stat_q[afe_pkg::EV_PB_BIT]; // see RULE13
      end
   end

   //////////////////////////////////////////////////////////////////////
   // pack detection and wake events
   logic hib, pack_d1_q, rx_d1_q;
   logic [4:0] ev_set;
   assign hib = wake_ctrl_q[afe_pkg::WK_HIB_BIT];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pack_d1_q <= 1'b0;
         rx_d1_q <= 1'b1;
      end else begin
         pack_d1_q <= pack_s;
         rx_d1_q <= rx_s;
      end
   end
   always_comb begin
      ev_set = 5'h00;
      ev_set[afe_pkg::EV_CHG_BIT] = wake_ctrl_q[afe_pkg::WK_CHG_EN_BIT] &&
                                    (pack_s != pack_d1_q); // see RULE8
      ev_set[afe_pkg::EV_LOAD_BIT] = load_detect_en && load_s; // see RULE10
      ev_set[afe_pkg::EV_SHORT_BIT] = load_detect_en && short_s; // see RULE10
      ev_set[afe_pkg::EV_PB_BIT] = pb_act_d;
      ev_set[afe_pkg::EV_RX_BIT] = hib && pb_ctrl_q[afe_pkg::PB_UART_BIT] &&
                                   rx_d1_q && !rx_s; // see RULE12
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         evt_stat_q <= 5'h00;
      else
         evt_stat_q <= (evt_stat_q & ~({5{clr_evt}} & wb_dat_i[4:0])) | ev_set;
   end

   // wake pulse out of hibernate
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         wake_event <= 1'b0;
      else
         wake_event <= hib && (ev_set[afe_pkg::EV_CHG_BIT] ||
            ev_set[afe_pkg::EV_RX_BIT] ||
            (pb_ctrl_q[afe_pkg::PB_WAKE_BIT] && pb_act_d)); // see RULE8 RULE13
   end

   // pack controls, detection held off in hibernate
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         charge_thr_sel <= 2'h0;
         pack_pull_down_en <= 1'b0;
         load_detect_en <= 1'b0;
      end else begin
         charge_thr_sel <= wake_ctrl_q[5:4]; // see RULE8
         pack_pull_down_en <= wake_ctrl_q[afe_pkg::WK_PD_EN_BIT]; // see RULE9
         load_detect_en <= wake_ctrl_q[afe_pkg::WK_LOAD_EN_BIT] && !hib
                           && !sel_bad; // see RULE10
      end
   end

endmodule

// [afe_checker_assertions.sv]
module afe_checker #(
   parameter int LONG_HOLD = 200,
   parameter int DG1 = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // bus handshake
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // analog side
   input wire logic [8:0] die_temp_channel,
   input wire logic push_button_input,
   input wire afe_pkg::power_en_t power_en,
   input wire afe_pkg::pb_bias_t pb_bias,
   input wire logic pb_irq,
   input wire logic hw_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] stable_q;
   logic last_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   ////////////////////////////////////////////////////////////////////////
   // cycles the raw button level has stayed unchanged
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stable_q <= 32'h0000_0000;
         last_q <= 1'b0;
      end else begin
         last_q <= push_button_input;
         if (push_button_input != last_q)
            stable_q <= 32'h0000_0000;
         else if (stable_q != 32'hFFFF_FFFF)
            stable_q <= stable_q + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // request, hot and cool windows
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence hot_s;
      (die_temp_channel > 9'h09B) [*6];
   endsequence
   sequence cool_s;
      (die_temp_channel < 9'h091) [*6];
   endsequence

   AST_ACK_NEXT: assert property (req_s |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |->
      $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   AST_FAULT_OFF: assert property (hot_s |-> power_en == 3'h0)
      else $error("power on while over fault level");
   AST_DCDC_BACK: assert property (cool_s |-> power_en.dcdc_en)
      else $error("dcdc still off after cooling");
   AST_RST_PULSE: assert property (hw_reset |=> !hw_reset)
      else $error("reset pulse too long");
   AST_RST_HOLD: assert property ($rose(hw_reset) |->
      stable_q >= LONG_HOLD) else $error("reset before long hold");
   AST_PB_DG: assert property ($rose(pb_irq) |->
      stable_q >= DG1) else $error("button event inside deglitch");
   AST_BIAS_ONE: assert property
      (!(pb_bias.pull_up_en && pb_bias.pull_down_en))
      else $error("both bias resistors on");
endmodule

bind afe_monitor_wake_protect afe_checker #(.LONG_HOLD(LONG_HOLD),
   .DG1(DG1)) chk (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .die_temp_channel(die_temp_channel),
   .push_button_input(push_button_input), .power_en(power_en),
   .pb_bias(pb_bias), .pb_irq(pb_irq), .hw_reset(hw_reset));

// [afe_far_side.sv]
module afe_far_side (
   // clock
   input wire logic sys_clk,
   // button state
   input wire logic pressed,
   input wire logic active_high,
   // bias from the block
   input wire afe_pkg::pb_bias_t pb_bias,
   // resolved pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flip_q = 1'b0;

   // a floating pin wanders every cycle
   always @(posedge sys_clk) flip_q <= ~flip_q;

   // released button leaves the pin to the bias resistor
   always_comb begin
      if (pressed)
         pin = active_high;
      else if (pb_bias.pull_up_en)
         pin = 1'b1;
      else if (pb_bias.pull_down_en)
         pin = 1'b0;
      else
         pin = flip_q;
   end
endmodule

// [tb_afe_monitor_wake_protect.sv]
module tb_afe_monitor_wake_protect;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DGT [4] = '{4, 8, 12, 16};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [4:0] seq_sel = 5'h00;
   logic [8:0] temp = 9'h019;
   logic pack = 1'b0;
   logic load = 1'b0;
   logic short_det = 1'b0;
   logic rx = 1'b1;
   logic pressed = 1'b0;
   logic act_hi = 1'b0;
   logic wake_seen = 1'b0;
   logic rst_seen = 1'b0;
   logic pb_pin;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic wb_ack_o, temp_irq, pb_irq, gpio, wake_event, hw_reset;
   logic pd_en, ld_en;
   logic [1:0] thr;
   afe_pkg::route_t route;
   afe_pkg::power_en_t power_en;
   afe_pkg::pb_bias_t pb_bias;
   int bad_count = 0;
   int tests_run = 0;

   initial forever #10 sys_clk = ~sys_clk;

   afe_monitor_wake_protect #(.LONG_HOLD(200), .DG1(4), .DG4(8), .DG8(12),
      .DG32(16)) dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .sequencer_channel_select(seq_sel),
      .die_temp_channel(temp), .pack_above_thr(pack),
      .load_detect_signal(load), .short_detect(short_det),
      .push_button_input(pb_pin), .uart_rx_pin(rx), .route(route),
      .power_en(power_en), .pb_bias(pb_bias), .charge_thr_sel(thr),
      .pack_pull_down_en(pd_en), .load_detect_en(ld_en),
      .temp_irq(temp_irq), .pb_irq(pb_irq), .shared_gpio_pin(gpio),
      .wake_event(wake_event), .hw_reset(hw_reset));

   afe_far_side far (.sys_clk(sys_clk), .pressed(pressed),
      .active_high(act_hi), .pb_bias(pb_bias), .pin(pb_pin));

   // catch single-cycle pulses
   always @(posedge sys_clk) begin
      if (wake_event === 1'b1)
         wake_seen <= 1'b1;
      if (hw_reset === 1'b1)
         rst_seen <= 1'b1;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // one classic cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      chk("wb_ack_o", 1, wb_ack_o);
      if (wb_ack_o !== 1'b1)
         conclude();
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      bus(1'b1, a, d, s);
      tick(2);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(nm, e, rd & m);
   endtask

   // bounded wait for a captured pulse
   task automatic wait_seen(input logic w, input int lim);
      int n;
      n = 0;
      @(posedge sys_clk); // let the caller's flag clear settle
      while ((w ? wake_seen : rst_seen) !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk(w ? "wake_event" : "hw_reset", 1, w ? wake_seen : rst_seen);
      if (n >= lim)
         conclude();
   endtask

   initial begin
      tick(50000);
      $display("[ERR] watchdog exp finished got hang");
      bad_count++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      tick(2);
      nrst <= 1'b1;
      tick(3);
      chk("power_en", 32'h7, power_en);
      rdc("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      wr(afe_pkg::MUX_CFG_OFS, afe_pkg::CH_DIE_TEMP, 4'h1);
      chk("monitor_sel", afe_pkg::CH_DIE_TEMP, route.monitor_sel);
      seq_sel <= 5'h0B;
      wr(afe_pkg::MUX_CFG_OFS, 32'h100, 4'h2);
      chk("seq_sel", 32'h0B, route.monitor_sel);
      wr(afe_pkg::MUX_CFG_OFS, 32'h0, 4'h2);
      chk("bus_sel", afe_pkg::CH_DIE_TEMP, route.monitor_sel);
      wr(afe_pkg::WAKE_CTRL_OFS, 32'h4, 4'h1);
      for (int i = 0; i < 22; i++) begin
         wr(afe_pkg::MUX_CFG_OFS, i, 4'h1);
         chk("load_en", i < 21, ld_en);
         if (i < 21)
            chk("channel", i, route.monitor_sel);
      end
      wr(afe_pkg::MUX_CFG_OFS, afe_pkg::CH_AIO_BUF, 4'h1);
      for (int i = 0; i < 4; i++) begin
         wr(afe_pkg::AIO_CFG_OFS, (i << 1) | 1, 4'h1);
         chk("aio_out", 4 | i, {route.aio_out_mode, route.aio_out_sel});
      end
      wr(afe_pkg::AIO_CFG_OFS, 32'h0, 4'h1);
      chk("aio_in", 1, {route.aio_out_mode, route.aio_to_monitor});
      // thermal ladder
      temp <= 9'h079;
      tick(8);
      chk("irq_masked", 0, temp_irq);
      rdc("warn1", afe_pkg::TEMP_STAT_OFS, 32'h7, 32'h1);
      wr(afe_pkg::TEMP_CTRL_OFS, 32'h1, 4'h1);
      tick(4);
      chk("temp_irq", 1, temp_irq);
      temp <= 9'h08D;
      tick(8);
      rdc("warn2", afe_pkg::TEMP_STAT_OFS, 32'h7, 32'h3);
      temp <= 9'h09C;
      tick(8);
      rdc("fault", afe_pkg::TEMP_STAT_OFS, 32'h7, 32'h7);
      chk("power_off", 0, power_en);
      temp <= 9'h096;
      tick(8);
      chk("dcdc_hyst", 0, power_en.dcdc_en);
      temp <= 9'h090;
      tick(8);
      chk("dcdc_back", 1, power_en.dcdc_en);
      temp <= 9'h019;
      tick(8);
      rdc("latched", afe_pkg::TEMP_STAT_OFS, 32'hFFF, 32'hCF);
      wr(afe_pkg::TEMP_STAT_OFS, 32'h7, 4'h1);
      tick(4);
      rdc("cleared", afe_pkg::TEMP_STAT_OFS, 32'hFFF, 32'hC8);
      chk("irq_clear", 0, temp_irq);
      // charger wake and load detect
      wr(afe_pkg::WAKE_CTRL_OFS, 32'h2F, 4'h1);
      chk("thr_sel", 2, thr);
      chk("pull_down", 1, pd_en);
      chk("load_hib", 0, ld_en);
      wake_seen <= 1'b0;
      pack <= 1'b1;
      wait_seen(1'b1, 50);
      wr(afe_pkg::WAKE_CTRL_OFS, 32'h7, 4'h1);
      chk("load_on", 1, ld_en);
      load <= 1'b1;
      short_det <= 1'b1;
      tick(8);
      rdc("load_evt", afe_pkg::EVT_STAT_OFS, 32'h6, 32'h6);
      load <= 1'b0;
      short_det <= 1'b0;
      tick(8);
      wr(afe_pkg::EVT_STAT_OFS, 32'h1F, 4'h1);
      rdc("evt_clr", afe_pkg::EVT_STAT_OFS, 32'h1F, 32'h0);
      // serial and button wake from hibernate
      wr(afe_pkg::PB_CTRL_OFS, 32'h40, 4'h1);
      wr(afe_pkg::WAKE_CTRL_OFS, 32'h8, 4'h1);
      wake_seen <= 1'b0;
      rx <= 1'b0;
      wait_seen(1'b1, 50);
      chk("gpio_rx", 0, gpio);
      rx <= 1'b1;
      act_hi <= 1'b1;
      wr(afe_pkg::PB_CTRL_OFS, 32'h7, 4'h1);
      chk("bias_hi", 1, pb_bias);
      wake_seen <= 1'b0;
      pressed <= 1'b1;
      wait_seen(1'b1, 100);
      pressed <= 1'b0;
      tick(30);
      wr(afe_pkg::WAKE_CTRL_OFS, 32'h0, 4'h1);
      wr(afe_pkg::PB_CTRL_OFS, 32'h2B, 4'h1);
      for (int i = 0; i < 4; i++) begin
         wr(afe_pkg::PB_CTRL_OFS, i << 8, 4'h2);
         wr(afe_pkg::EVT_STAT_OFS, 32'h8, 4'h1);
         pressed <= 1'b1;
         tick(DGT[i] - 2);
         pressed <= 1'b0;
         tick(30);
         chk("glitch", 0, pb_irq);
         pressed <= 1'b1;
         tick(DGT[i] + 8);
         chk("pb_irq", 1, pb_irq);
         chk("gpio", 1, gpio);
         pressed <= 1'b0;
         tick(30);
      end
      wr(afe_pkg::PB_CTRL_OFS, 32'h13, 4'h1);
      rst_seen <= 1'b0;
      pressed <= 1'b1;
      wait_seen(1'b0, 400);
      pressed <= 1'b0;
      act_hi <= 1'b0;
      wr(afe_pkg::PB_CTRL_OFS, 32'h1, 4'h1);
      chk("bias_lo", 2, pb_bias);
      conclude();
   end
endmodule
